/* File: rtl/eapc_top.sv */
`timescale 1ns/1ps
`include "eapc_map.svh"
// Notes on behaviour
// R1: Each axis takes its position from any one of six inputs, or none.
// R2: An axis may be first input plus or minus the second input.
// R3: Each axis holds a letter label from A to Z.
// R4: Linear inputs take any signal period; default is 20 um.
// R5: Rotary inputs take a line count instead; linear is the default type.
// R6: Each input has a display resolution; default linear resolution is 1 um.
// R7: Reference marks per input are none, single or distance coded.
// R8: Coded mark spacing is 500, 1000, 2000 or 5000; default coded 1000.
// R9: Per-input count direction; negative inverts counting; default positive.
// R10: Per-input signal and slew error monitoring, on by default.
// R11: An error indication stays raised until a clear-entry command removes it.
// R12: Rotary angles wrap to 0..360, -180..180, or run unbounded; default 0..360.
// R13: Each input's signal presence is found by the device itself.
// R14: With monitoring off, errors are suppressed but counting continues.
// R15: Inputs assigned to no axis contribute nothing to any axis.
module eapc_top
  import eapc_pkg::*;
#(
  parameter int NIN = 6,
  parameter int NAX = 6,
  parameter int CW  = 32
) (
  // Clock and reset.
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // Avalon-MM slave.
  input  wire logic [7:0]        i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output logic      [31:0]       o_avs_readdata,
  output logic                   o_avs_waitrequest,
  // Encoder inputs.
  input  wire logic [NIN-1:0]    i_enc_a,
  input  wire logic [NIN-1:0]    i_enc_b,
  input  wire logic [NIN-1:0]    i_enc_ref,
  input  wire logic [NIN-1:0]    i_enc_sig_ok,
  // Axis values and indications.
  output logic [NAX*CW-1:0]      o_axis_value,
  output logic [NIN-1:0]         o_err_ind,
  output logic                   o_irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave: every access takes one wait cycle, then completes.

  logic        ack_reg;
  logic        req;
  logic        wr_now;
  logic [31:0] be_mask;
  logic [31:0] rd_next;
  logic [2:0]  widx;
  logic        clr_pulse;

  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_reg;
  // A write lands on the edge where the master sees waitrequest low.
  assign wr_now            = i_avs_write & ack_reg;
  assign be_mask           = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                              {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  assign widx              = i_avs_address[4:2];
  assign clr_pulse         = wr_now && i_avs_address == `EAPC_CTRL_OFS
                             && i_avs_byteenable[0] && i_avs_writedata[`EAPC_CTRL_CLR];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  logic [31:0] enc_cfg_reg [NIN];
  logic [31:0] enc_per_reg [NIN];
  logic [31:0] enc_res_reg [NIN];
  logic [31:0] axis_cfg_reg [NAX];
  logic [31:0] irq_mask_reg;

  // Default axis letters X, Y, Z, W, U, V as alphabet indices.
  localparam logic [4:0] DEF_LBL [6] = '{5'h17, 5'h18, 5'h19, 5'h16, 5'h14, 5'h15};

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_enc_cfg
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          enc_cfg_reg[gi] <= `EAPC_ECFG_RST; // [R5] [R8] [R9] [R10] [R12]
          enc_per_reg[gi] <= `EAPC_PERIOD_RST_NM; // [R4]
          enc_res_reg[gi] <= `EAPC_RES_RST_NM; // [R6]
        end else if (wr_now && widx == 3'(gi)) begin
          if (i_avs_address[7:5] == 3'h1) begin
            enc_cfg_reg[gi] <= (enc_cfg_reg[gi] & ~be_mask)
                               | (i_avs_writedata & be_mask & 32'h0000_01ff);
          end
          if (i_avs_address[7:5] == 3'h2) begin
            enc_per_reg[gi] <= (enc_per_reg[gi] & ~be_mask) | (i_avs_writedata & be_mask);
          end
          if (i_avs_address[7:5] == 3'h3) begin
            enc_res_reg[gi] <= (enc_res_reg[gi] & ~be_mask) | (i_avs_writedata & be_mask);
          end
        end
      end
    end
    for (gi = 0; gi < NAX; gi++) begin : g_axis_cfg
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          axis_cfg_reg[gi] <= {20'h0, DEF_LBL[gi % 6], 4'h0, 3'(gi % NIN + 1)}; // [R1] [R3]
        end else if (wr_now && widx == 3'(gi) && i_avs_address[7:5] == 3'h4) begin
          axis_cfg_reg[gi] <= (axis_cfg_reg[gi] & ~be_mask)
                              | (i_avs_writedata & be_mask & 32'h0000_0fff);
          // Letters beyond Z are refused; the old label stays.
          if (i_avs_byteenable[1] && i_avs_writedata[11:7] > 5'h19) begin // [R3]
            axis_cfg_reg[gi][11:7] <= axis_cfg_reg[gi][11:7];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_mask_reg <= 32'h0;
    end else if (wr_now && i_avs_address == `EAPC_IRQ_MASK_OFS) begin
      irq_mask_reg <= (irq_mask_reg & ~be_mask) | (i_avs_writedata & be_mask & 32'h0003_ffff);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Encoder channels.

  logic signed [CW-1:0] enc_pos [NIN];
  logic [NIN-1:0]       err_sig;
  logic [NIN-1:0]       err_slew;
  logic [NIN-1:0]       ref_seen;
  logic [NIN-1:0]       detected;

  generate
    for (gi = 0; gi < NIN; gi++) begin : g_chan
      eapc_enc_chan #(.CW(CW)) u_chan (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_a        (i_enc_a[gi]),
        .i_b        (i_enc_b[gi]),
        .i_ref      (i_enc_ref[gi]),
        .i_sig_ok   (i_enc_sig_ok[gi]),
        .i_rotary   (enc_cfg_reg[gi][`EAPC_ECFG_ROT]), // [R5]
        .i_dir_neg  (enc_cfg_reg[gi][`EAPC_ECFG_NEG]), // [R9]
        .i_mon_en   (enc_cfg_reg[gi][`EAPC_ECFG_MON]), // [R10]
        .i_ref_type (eapc_ref_t'(enc_cfg_reg[gi][`EAPC_ECFG_REF_LO +: 2])), // [R7]
        .i_ang_mode (eapc_angle_t'(enc_cfg_reg[gi][`EAPC_ECFG_ANG_LO +: 2])), // [R12]
        .i_period   (enc_per_reg[gi]),
        .o_pos      (enc_pos[gi]),
        .o_err_sig  (err_sig[gi]),
        .o_err_slew (err_slew[gi]),
        .o_ref_seen (ref_seen[gi]),
        .o_detected (detected[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Axes: select sources and scale.

  logic signed [CW-1:0] axis_val [NAX];

  generate
    for (gi = 0; gi < NAX; gi++) begin : g_axis
      logic [2:0] s1;
      logic [2:0] s2;
      logic       use1;
      logic       use2;
      assign s1   = axis_cfg_reg[gi][`EAPC_ACFG_SRC1_LO +: 3];
      assign s2   = axis_cfg_reg[gi][`EAPC_ACFG_SRC2_LO +: 3];
      // Source code 0 is OFF; codes above the input count are treated as OFF too.
      assign use1 = s1 != 3'h0 && 32'(s1) <= NIN; // [R1] [R15]
      assign use2 = s2 != 3'h0 && 32'(s2) <= NIN; // [R2] [R15]
      eapc_axis #(.CW(CW)) u_axis (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_use1  (use1),
        .i_use2  (use2),
        .i_sub   (axis_cfg_reg[gi][`EAPC_ACFG_SUB]), // [R2]
        .i_pos1  (use1 ? enc_pos[s1 - 3'h1] : '0),
        .i_pos2  (use2 ? enc_pos[s2 - 3'h1] : '0),
        .i_res   (use1 ? enc_res_reg[s1 - 3'h1] : 32'h0000_0001), // [R6]
        .o_value (axis_val[gi])
      );
      assign o_axis_value[gi*CW +: CW] = axis_val[gi];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Error indication, sticky status and interrupt.

  logic [NIN-1:0] err_ind_reg;
  logic [31:0]    irq_stat_reg;
  logic [31:0]    ev;
  logic [31:0]    w1c;

  assign ev  = {14'h0, ref_seen, err_slew, err_sig};
  assign w1c = (wr_now && i_avs_address == `EAPC_IRQ_STAT_OFS) ? (i_avs_writedata & be_mask)
                                                               : 32'h0;

  // A new error in the clearing cycle survives the clear.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      err_ind_reg <= '0;
    end else begin
      err_ind_reg <= (clr_pulse ? '0 : err_ind_reg) | err_sig | err_slew; // [R11]
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_stat_reg <= 32'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~w1c) | ev;
    end
  end

  assign o_err_ind = err_ind_reg;
  assign o_irq     = |(irq_stat_reg & irq_mask_reg);

  //////////////////////////////////////////////////////////////////////////////
  // Read data, sampled in the wait cycle.

  always_comb begin
    rd_next = 32'h0;
    case (i_avs_address[7:5])
      3'h0: begin
        case (i_avs_address)
          `EAPC_IRQ_STAT_OFS: rd_next = irq_stat_reg;
          `EAPC_IRQ_MASK_OFS: rd_next = irq_mask_reg;
          `EAPC_ERR_IND_OFS:  rd_next = 32'(err_ind_reg); // [R11]
          `EAPC_DETECT_OFS:   rd_next = 32'(detected); // [R13]
          default:            rd_next = 32'h0;
        endcase
      end
      3'h1: if (32'(widx) < NIN) rd_next = enc_cfg_reg[widx];
      3'h2: if (32'(widx) < NIN) rd_next = enc_per_reg[widx];
      3'h3: if (32'(widx) < NIN) rd_next = enc_res_reg[widx];
      3'h4: if (32'(widx) < NAX) rd_next = axis_cfg_reg[widx];
      3'h5: if (32'(widx) < NAX) rd_next = 32'(axis_val[widx]);
      default: rd_next = 32'h0;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_avs_readdata <= 32'h0;
    end else if (i_avs_read && !ack_reg) begin
      o_avs_readdata <= rd_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_bus_one_wait: assert property (@(posedge i_clk) disable iff (i_rst)
    req && !ack_reg |-> o_avs_waitrequest ##1 (!req || !o_avs_waitrequest))
    else $error("bus answer not after one wait");
  a_err_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    clr_pulse && !(|(err_sig | err_slew)) |=> err_ind_reg == '0) // [R11]
    else $error("clear entry did not remove errors");
  a_err_sticky: assert property (@(posedge i_clk) disable iff (i_rst)
    !clr_pulse |=> (err_ind_reg & $past(err_ind_reg)) == $past(err_ind_reg)) // [R11]
    else $error("error indication dropped early");
  a_err_raise: assert property (@(posedge i_clk) disable iff (i_rst)
    |(err_sig | err_slew) |=> (err_ind_reg & $past(err_sig | err_slew)) != '0) // [R11]
    else $error("error not indicated");
  a_stat_sticky: assert property (@(posedge i_clk) disable iff (i_rst)
    w1c == 32'h0 |=> (irq_stat_reg & $past(irq_stat_reg)) == $past(irq_stat_reg))
    else $error("status bit lost without clear");
  a_label_refused: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_now && i_avs_address == `EAPC_AXIS_CFG_OFS && i_avs_byteenable[1]
      && i_avs_writedata[11:7] > 5'h19 |=> axis_cfg_reg[0][11:7] <= 5'h19) // [R3]
    else $error("label beyond the alphabet accepted");
  c_read: cover property (@(posedge i_clk) disable iff (i_rst)
    i_avs_read && !o_avs_waitrequest);
  c_clear: cover property (@(posedge i_clk) disable iff (i_rst)
    |err_ind_reg ##1 clr_pulse ##1 err_ind_reg == '0);

endmodule

/* File: rtl/eapc_map.svh */
`ifndef EAPC_MAP_SVH
`define EAPC_MAP_SVH

// Register byte offsets.
`define EAPC_CTRL_OFS       8'h00
`define EAPC_IRQ_STAT_OFS   8'h04
`define EAPC_IRQ_MASK_OFS   8'h08
`define EAPC_ERR_IND_OFS    8'h0c
`define EAPC_DETECT_OFS     8'h10
`define EAPC_ENC_CFG_OFS    8'h20
`define EAPC_ENC_PER_OFS    8'h40
`define EAPC_ENC_RES_OFS    8'h60
`define EAPC_AXIS_CFG_OFS   8'h80
`define EAPC_AXIS_POS_OFS   8'ha0

// Encoder configuration fields.
`define EAPC_ECFG_ROT       0
`define EAPC_ECFG_NEG       1
`define EAPC_ECFG_MON       2
`define EAPC_ECFG_REF_LO    3
`define EAPC_ECFG_SPC_LO    5
`define EAPC_ECFG_ANG_LO    7
`define EAPC_ECFG_RST       32'h0000_0034

// Axis configuration fields.
`define EAPC_ACFG_SRC1_LO   0
`define EAPC_ACFG_SRC2_LO   3
`define EAPC_ACFG_SUB       6
`define EAPC_ACFG_LBL_LO    7

// Control and status fields.
`define EAPC_CTRL_CLR       0
`define EAPC_ST_SIG_LO      0
`define EAPC_ST_SLEW_LO     6
`define EAPC_ST_REF_LO      12

// Reset values: 20 um period and 1 um resolution, both in nanometres.
`define EAPC_PERIOD_RST_NM  32'd20000
`define EAPC_RES_RST_NM     32'd1000

`endif

/* File: rtl/eapc_pkg.sv */
package eapc_pkg;

  typedef enum logic [1:0] {
    EAPC_REF_NONE   = 2'h0,
    EAPC_REF_SINGLE = 2'h1,
    EAPC_REF_CODED  = 2'h2
  } eapc_ref_t;

  typedef enum logic [1:0] {
    EAPC_SPC_500  = 2'h0,
    EAPC_SPC_1000 = 2'h1,
    EAPC_SPC_2000 = 2'h2,
    EAPC_SPC_5000 = 2'h3
  } eapc_spacing_t;

  typedef enum logic [1:0] {
    EAPC_ANG_360 = 2'h0,
    EAPC_ANG_180 = 2'h1,
    EAPC_ANG_INF = 2'h2
  } eapc_angle_t;

  typedef enum logic [1:0] {
    EAPC_DIV_IDLE = 2'b00,
    EAPC_DIV_RUN  = 2'b01,
    EAPC_DIV_DONE = 2'b11
  } eapc_div_state_t;

endpackage

/* File: rtl/eapc_enc_chan.sv */
`timescale 1ns/1ps
module eapc_enc_chan
  import eapc_pkg::*;
#(
  parameter int CW = 32
) (
  // Clock and reset.
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  // Encoder signals.
  input  wire logic          i_a,
  input  wire logic          i_b,
  input  wire logic          i_ref,
  input  wire logic          i_sig_ok,
  // Configuration.
  input  wire logic          i_rotary,
  input  wire logic          i_dir_neg,
  input  wire logic          i_mon_en,
  input  wire eapc_ref_t     i_ref_type,
  input  wire eapc_angle_t   i_ang_mode,
  input  wire logic [31:0]   i_period,
  // Results.
  output logic signed [CW-1:0] o_pos,
  output logic               o_err_sig,
  output logic               o_err_slew,
  output logic               o_ref_seen,
  output logic               o_detected
);

  logic                 a_reg;
  logic                 b_reg;
  logic                 ref_reg;
  logic                 datum_done_reg;
  logic signed [CW-1:0] count_reg;
  logic signed [CW-1:0] count_next;
  logic signed [CW-1:0] full;
  logic                 moved;
  logic                 slew;
  logic                 up;
  logic                 ref_rise;
  logic                 ref_clear;
  logic [31:0]          step;

  assign moved     = (i_a ^ a_reg) ^ (i_b ^ b_reg);
  assign slew      = (i_a ^ a_reg) & (i_b ^ b_reg);
  assign up        = (i_a ^ b_reg) ^ i_dir_neg; // [R9]
  assign ref_rise  = i_ref & ~ref_reg & (i_ref_type != EAPC_REF_NONE); // [R7]
  assign ref_clear = ref_rise & (i_ref_type == EAPC_REF_SINGLE) & ~datum_done_reg; // [R7]
  // A rotary input counts four edges per line.
  assign full      = CW'({i_period, 2'b00});
  assign step      = i_rotary ? 32'h0000_0001 : {2'b00, i_period[31:2]}; // [R4] [R5]

  always_comb begin
    count_next = count_reg;
    if (moved) begin
      count_next = up ? count_reg + 1 : count_reg - 1;
    end
    if (i_rotary) begin // [R12]
      case (i_ang_mode)
        EAPC_ANG_360: begin
          if (count_next >= full) count_next = count_next - full;
          else if (count_next < 0) count_next = count_next + full;
        end
        EAPC_ANG_180: begin
          if (count_next >= (full >>> 1)) count_next = count_next - full;
          else if (count_next < -(full >>> 1)) count_next = count_next + full;
        end
        default: count_next = count_next;
      endcase
    end
    if (ref_clear) count_next = '0;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      a_reg   <= 1'b0;
      b_reg   <= 1'b0;
      ref_reg <= 1'b0;
    end else begin
      a_reg   <= i_a;
      b_reg   <= i_b;
      ref_reg <= i_ref;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count_reg      <= '0;
      datum_done_reg <= 1'b0;
      o_pos          <= '0;
    end else begin
      count_reg <= count_next; // [R14]
      if (ref_clear) datum_done_reg <= 1'b1;
      o_pos <= CW'(count_reg * $signed({1'b0, step}));
    end
  end

  // Errors are only reported while monitoring is on; counting never stops.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_err_sig  <= 1'b0;
      o_err_slew <= 1'b0;
      o_ref_seen <= 1'b0;
      o_detected <= 1'b0;
    end else begin
      o_err_sig  <= i_mon_en & ~i_sig_ok & o_detected; // [R10] [R14]
      o_err_slew <= i_mon_en & slew; // [R10] [R14]
      o_ref_seen <= ref_rise;
      if (moved | slew | i_ref) o_detected <= 1'b1; // [R13]
    end
  end

  a_mon_off_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_mon_en) |-> !o_err_sig && !o_err_slew) // [R14]
    else $error("error raised with monitoring off");
  a_dir_count: assert property (@(posedge i_clk) disable iff (i_rst)
    moved && !i_rotary && !ref_clear |=> count_reg == $past(count_reg) + (
      ($past(i_a) ^ $past(b_reg)) ^ $past(i_dir_neg) ? 1 : -1)) // [R9]
    else $error("count moved the wrong way");
  a_rot_range: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rotary && i_ang_mode == EAPC_ANG_360 && $stable(i_period) && $stable(i_ang_mode)
      && $stable(i_rotary) && $past(count_reg) >= 0 && $past(count_reg) < full
      |-> count_reg >= 0 && count_reg < full) // [R12]
    else $error("angle left 0 to 360 range");
  a_detect_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    o_detected |=> o_detected) // [R13]
    else $error("detection dropped");
  c_slew: cover property (@(posedge i_clk) disable iff (i_rst) o_err_slew);

endmodule

/* File: rtl/eapc_axis.sv */
`timescale 1ns/1ps
module eapc_axis
  import eapc_pkg::*;
#(
  parameter int CW = 32
) (
  // Clock and reset.
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  // Sources, already selected.
  input  wire logic          i_use1,
  input  wire logic          i_use2,
  input  wire logic          i_sub,
  input  wire logic signed [CW-1:0] i_pos1,
  input  wire logic signed [CW-1:0] i_pos2,
  input  wire logic [31:0]   i_res,
  // Display value in resolution steps.
  output logic signed [CW-1:0] o_value
);

  logic signed [CW-1:0] sum;
  logic signed [CW-1:0] p1;
  logic signed [CW-1:0] p2;
  eapc_div_state_t      st_reg;
  logic [CW-1:0]        num_reg;
  logic [CW-1:0]        quo_reg;
  logic [CW:0]          rem_reg;
  logic [CW:0]          trial;
  logic [31:0]          den_reg;
  logic                 neg_reg;
  logic [$clog2(CW+1)-1:0] bit_reg;

  assign p1    = i_use1 ? i_pos1 : '0; // [R15]
  assign p2    = i_use2 ? i_pos2 : '0; // [R15]
  assign sum   = i_sub ? p1 - p2 : p1 + p2; // [R2]
  assign trial = {rem_reg[CW-1:0], num_reg[CW-1]} - {1'b0, den_reg};

  // A restoring divider converts the summed position into resolution steps.
  // It trades latency (CW+2 cycles) for area; the display is far slower.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg  <= EAPC_DIV_IDLE;
      num_reg <= '0;
      quo_reg <= '0;
      rem_reg <= '0;
      den_reg <= 32'h0000_0001;
      neg_reg <= 1'b0;
      bit_reg <= '0;
      o_value <= '0;
    end else begin
      case (st_reg)
        EAPC_DIV_IDLE: begin
          neg_reg <= sum[CW-1];
          num_reg <= sum[CW-1] ? CW'(-sum) : sum;
          den_reg <= (i_res == 32'h0) ? 32'h0000_0001 : i_res; // [R6]
          rem_reg <= '0;
          quo_reg <= '0;
          bit_reg <= '0;
          st_reg  <= EAPC_DIV_RUN;
        end
        EAPC_DIV_RUN: begin
          num_reg <= {num_reg[CW-2:0], 1'b0};
          if (!trial[CW]) begin
            rem_reg <= trial;
            quo_reg <= {quo_reg[CW-2:0], 1'b1};
          end else begin
            rem_reg <= {rem_reg[CW-1:0], num_reg[CW-1]};
            quo_reg <= {quo_reg[CW-2:0], 1'b0};
          end
          bit_reg <= bit_reg + 1'b1;
          if (bit_reg == ($clog2(CW+1))'(CW-1)) st_reg <= EAPC_DIV_DONE;
        end
        EAPC_DIV_DONE: begin
          o_value <= neg_reg ? CW'(-quo_reg) : quo_reg; // [R6]
          st_reg  <= EAPC_DIV_IDLE;
        end
        default: st_reg <= EAPC_DIV_IDLE;
      endcase
    end
  end

  a_axis_off: assert property (@(posedge i_clk) disable iff (i_rst)
    st_reg == EAPC_DIV_IDLE && !i_use1 && !i_use2 |=> num_reg == '0 && !neg_reg) // [R15]
    else $error("unused inputs reach the axis");
  a_div_period: assert property (@(posedge i_clk) disable iff (i_rst)
    st_reg == EAPC_DIV_IDLE |=> st_reg == EAPC_DIV_RUN ##32 st_reg == EAPC_DIV_DONE) // [R6]
    else $error("divider cycle length wrong");
  c_sub_axis: cover property (@(posedge i_clk) disable iff (i_rst)
    i_use1 && i_use2 && i_sub && st_reg == EAPC_DIV_DONE);

endmodule

/* File: sim/eapc_enc_model.sv */
`timescale 1ns/1ps
// Quadrature source per input: one count step or one slew per requesting clock.
module eapc_enc_model #(
  parameter int N = 6
) (
  // Clock.
  input  wire logic         i_clk,
  // Requests from the bench.
  input  wire logic [N-1:0] i_step,
  input  wire logic [N-1:0] i_down,
  input  wire logic [N-1:0] i_slew,
  input  wire logic [N-1:0] i_mark,
  input  wire logic [N-1:0] i_bad,
  // Encoder signals.
  output logic      [N-1:0] o_a,
  output logic      [N-1:0] o_b,
  output logic      [N-1:0] o_ref,
  output logic      [N-1:0] o_sig_ok
);
  logic [1:0] ph_reg [N] = '{default: 2'h0};

  always_ff @(posedge i_clk) begin
    for (int k = 0; k < N; k++) begin
      // A slew jumps two phases, so both lines flip in the same cycle.
      if (i_slew[k]) ph_reg[k] <= ph_reg[k] + 2'h2;
      else if (i_step[k]) ph_reg[k] <= i_down[k] ? ph_reg[k] - 2'h1 : ph_reg[k] + 2'h1;
    end
  end

  always_comb begin
    for (int k = 0; k < N; k++) begin
      o_a[k] = ph_reg[k][1] ^ ph_reg[k][0];
      o_b[k] = ph_reg[k][1];
    end
  end

  assign o_ref    = i_mark;
  assign o_sig_ok = ~i_bad;
endmodule

/* File: sim/encoder_axis_position_config_tb.sv */
`timescale 1ns/1ps
module encoder_axis_position_config_tb;
  import eapc_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic        rd_s = 1'b0;
  logic        wr_s = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  logic [5:0]  a, b, rf, ok, step = 6'h0, dn = 6'h0, slew = 6'h0, o_err_ind;
  logic [5:0]  mk = 6'h0, bad = 6'h0;
  logic [191:0] o_axis_value;
  logic        o_irq;
  logic [31:0] r;
  int          fail_count = 0;
  int          n_tests = 0;
  int          cyc = 0;

  always #4 i_clk = ~i_clk;

  eapc_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(rd_s),
    .i_avs_write(wr_s), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_enc_a(a), .i_enc_b(b), .i_enc_ref(rf), .i_enc_sig_ok(ok),
    .o_axis_value(o_axis_value), .o_err_ind(o_err_ind), .o_irq(o_irq));
  eapc_enc_model #(.N(6)) enc (.i_clk(i_clk), .i_step(step), .i_down(dn), .i_slew(slew),
    .i_mark(mk), .i_bad(bad), .o_a(a), .o_b(b), .o_ref(rf), .o_sig_ok(ok));

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Requests are held until waitrequest is sampled low; read data taken at that edge.
  task automatic av(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge i_clk);
    adr  <= ad;
    wd   <= d;
    wr_s <= w;
    rd_s <= !w;
    @(posedge i_clk);
    while (o_avs_waitrequest !== 1'b0) @(posedge i_clk);
    r = o_avs_readdata;
    rd_s <= 1'b0;
    wr_s <= 1'b0;
  endtask

  // Two clocks per step keep a count step to one line change per cycle at most.
  task automatic mv(input int k, input int n, input logic d, input logic s);
    repeat (n) begin
      @(posedge i_clk);
      step[k] <= !s;
      slew[k] <= s;
      dn[k]   <= d;
      @(posedge i_clk);
      step[k] <= 1'b0;
      slew[k] <= 1'b0;
    end
  endtask

  // A change may miss one divider pass, so wait out two full passes first.
  task automatic axis_is(input int j, input logic [31:0] e);
    repeat (80) @(posedge i_clk);
    cmp(o_axis_value[j*32 +: 32], e);
  endtask

  task automatic mark(input int k);
    @(posedge i_clk);
    mk[k] <= 1'b1;
    @(posedge i_clk);
    mk[k] <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    for (int i = 0; i < 6; i++) begin
      av(1'b0, 8'h20 + 8'(4 * i), 32'h0);
      cmp(r, 32'h0000_0034);
    end
    av(1'b0, 8'h40, 32'h0);
    cmp(r, 32'd20000);
    av(1'b0, 8'h60, 32'h0);
    cmp(r, 32'd1000);
    av(1'b0, 8'h80, 32'h0);
    cmp(r, 32'h0000_0b81);
    av(1'b1, 8'h80, 32'h0000_0c81);
    av(1'b0, 8'h80, 32'h0);
    cmp(r, 32'h0000_0c81);
    av(1'b1, 8'h80, 32'h0000_0d01);
    av(1'b0, 8'h80, 32'h0);
    cmp(r, 32'h0000_0c81);
    av(1'b0, 8'hfc, 32'h0);
    cmp(r, 32'h0);
  endtask

  task automatic t_count();
    mv(0, 4, 1'b0, 1'b0);
    axis_is(0, 32'd20);
    av(1'b1, 8'h24, 32'h0000_0036);
    mv(1, 4, 1'b0, 1'b0);
    axis_is(1, -32'sd20);
    av(1'b1, 8'h94, 32'h0000_0a91);
    axis_is(5, 32'd0);
    av(1'b1, 8'h94, 32'h0000_0ad1);
    axis_is(5, 32'd40);
    av(1'b1, 8'h84, 32'h0000_0c00);
    axis_is(1, 32'd0);
  endtask

  // A coded mark leaves the count alone; a single mark sets the datum.
  task automatic t_refmark();
    mark(0);
    axis_is(0, 32'd20);
    av(1'b1, 8'h20, 32'h0000_002c);
    mark(0);
    axis_is(0, 32'd0);
    av(1'b0, 8'h04, 32'h0);
    cmp({31'h0, r[12]}, 32'h1);
  endtask

  task automatic t_rotary();
    av(1'b1, 8'h30, 32'h0000_0035);
    av(1'b1, 8'h50, 32'd1);
    av(1'b1, 8'h70, 32'd1);
    mv(4, 5, 1'b0, 1'b0);
    axis_is(4, 32'd1);
    av(1'b1, 8'h30, 32'h0000_00b5);
    mv(4, 1, 1'b0, 1'b0);
    axis_is(4, -32'sd2);
    av(1'b1, 8'h30, 32'h0000_0135);
    mv(4, 3, 1'b1, 1'b0);
    axis_is(4, -32'sd5);
  endtask

  task automatic t_errors();
    mv(2, 1, 1'b0, 1'b0);
    av(1'b0, 8'h10, 32'h0);
    cmp({30'h0, r[5], r[2]}, 32'h1);
    mv(2, 1, 1'b0, 1'b1);
    repeat (4) @(posedge i_clk);
    cmp({31'h0, o_err_ind[2]}, 32'h1);
    av(1'b1, 8'h08, 32'h0000_0100);
    @(posedge i_clk);
    cmp({31'h0, o_irq}, 32'h1);
    av(1'b1, 8'h04, 32'h0000_0100);
    @(posedge i_clk);
    cmp({30'h0, o_err_ind[2], o_irq}, 32'h2);
    av(1'b1, 8'h00, 32'h0000_0001);
    repeat (2) @(posedge i_clk);
    cmp({30'h0, o_err_ind[2], o_irq}, 32'h0);
    av(1'b1, 8'h2c, 32'h0000_0030);
    mv(3, 1, 1'b0, 1'b0);
    mv(3, 1, 1'b0, 1'b1);
    mv(3, 1, 1'b0, 1'b0);
    cmp({31'h0, o_err_ind[3]}, 32'h0);
    axis_is(3, 32'd10);
    // Bad signal on inputs 2, 3 and 5: only the monitored, detected one reports.
    bad <= 6'h2c;
    repeat (3) @(posedge i_clk);
    cmp({26'h0, o_err_ind}, 32'h4);
    bad <= 6'h00;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    t_defaults();
    t_count();
    t_refmark();
    t_rotary();
    t_errors();
    print_verdict();
  end
endmodule
